// ### nvsc_pkg.sv
// Purpose: constants and types for the nonvolatile sram host controller
// Assumes: MCLK at 250 MHz; timing figures in ns below (recall in us), converted to cycles
// Notes:   counts round up so every pin phase lasts at least its time
// Functional notes
// RL1: device refuses accesses during store or recall
// RL2: read only with CE, OE low, WE, busy high
// RL3: address picks bytes or 16-bit words
// RL4: read drives only enabled byte lanes
// RL5: read data follows address until control changes
// RL6: write when CE, WE low, busy high
// RL7: address stable through write, data taken at rise
// RL8: write stores only enabled byte lanes
// RL9: keep OE high during writes
// RL10: three store initiators, auto store default on
// RL11: supply drop starts store from backup capacitor
// RL12: auto and pin stores need prior write
// RL13: software stores always execute
// RL14: pulled-low busy pin requests delayed store
// RL15: device drives busy low during store
// RL16: device drives busy high briefly after store
// RL17: writes after busy falls are blocked
// RL18: no write: pin stays low until host releases
// RL19: accesses refused for lockout after busy rises
// RL20: power-up latches and runs recall
// RL21: busy low, accesses refused during power-up recall
// RL22: low lane enable gates bits 7..0, high 15..8
// RL23: write flag set by write, cleared by transfer
package nvsc_pkg;
    localparam int CLK_PERIOD_NS = 4;

    // least times round up, never below one cycle
    function automatic int min_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : min_cycles

    localparam int T_ACCESS_NS         = 25;  // address/select to data valid
    localparam int T_WE_PULSE_NS       = 20;  // write enable low time
    localparam int T_OUTPUT_OFF_NS     = 10;  // write_output_off_delay margin
    localparam int T_STORE_PULSE_NS    = 100; // host pull on store_busy_n
    localparam int T_LOCKOUT_NS        = 20;  // post_busy_lockout
    localparam int T_POWERUP_RECALL_US = 20000; // powerup_recall_time

    localparam int SYNC_STAGES      = 2;
    localparam int ACCESS_CYC       = min_cycles(T_ACCESS_NS);
    localparam int RD_CYC           = ACCESS_CYC + SYNC_STAGES;
    localparam int WE_CYC           = min_cycles(T_WE_PULSE_NS);
    localparam int TURN_CYC         = min_cycles(T_OUTPUT_OFF_NS);
    localparam int STORE_PULSE_CYC  = min_cycles(T_STORE_PULSE_NS);
    localparam int LOCKOUT_CYC      = min_cycles(T_LOCKOUT_NS);
    localparam int RECALL_CYC       = min_cycles(T_POWERUP_RECALL_US * 1000);

    localparam logic [7:0] CNT_W8_ONE = 8'h01;

    typedef enum logic [5:0] {
        S_WAIT     = 6'h01,
        S_IDLE     = 6'h02,
        S_RD       = 6'h04,
        S_WR_SETUP = 6'h08,
        S_WR_PULSE = 6'h10,
        S_WR_END   = 6'h20
    } nvsc_state_t;
endpackage : nvsc_pkg

// ### nvsc_busy_if.sv
// Purpose: carries busy-pin status and store requests inside the controller
// Assumes: one clock domain
// Notes:   monitor drives status, the access engine drives store_go
`timescale 1ns/100ps
interface nvsc_busy_if;
    logic access_ok;  // accesses may start
    logic pull_idle;  // monitor not pulling the pin
    logic busy;       // synchronised store_busy_n is low
    logic store_go;   // one-cycle store request
    modport mon (input store_go, output access_ok, pull_idle, busy);
    modport ctl (output store_go, input access_ok, pull_idle, busy);
endinterface : nvsc_busy_if

// ### nvsc_busy_mon.sv
// Purpose: watch and request on the open-drain store_busy_n pin
// Assumes: pin level is asynchronous to MCLK
// Notes:   access_ok stays low through startup, pulls, busy and lockout
`timescale 1ns/100ps
module nvsc_busy_mon #(
    parameter int STARTUP_CYC = nvsc_pkg::RECALL_CYC
) (
    input  wire logic   clk,
    input  wire logic   rst_n,
    input  wire logic   sb_i,
    output logic        sb_o,
    output logic        sb_oe,
    nvsc_busy_if.mon    bus
);
    localparam int SW = $clog2(STARTUP_CYC + 1);
    localparam int PW = $clog2(nvsc_pkg::STORE_PULSE_CYC + 1);
    localparam int LW = $clog2(nvsc_pkg::LOCKOUT_CYC + 1);

    if (STARTUP_CYC < 1) begin : g_chk
        $error("STARTUP_CYC must be at least 1");
    end

    logic          meta_ff;
    logic          sync_ff;
    logic [PW-1:0] pull_cnt_ff;
    logic [LW-1:0] lock_cnt_ff;
    logic [SW-1:0] start_cnt_ff;
    logic          sb_oe_ff;

    // two stages before any logic reads the pin
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= sb_i;
            sync_ff <= meta_ff;
        end
    end

    // host pull: held long enough for the device to latch the request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pull_cnt_ff <= '0;
            sb_oe_ff    <= 1'b0;
        end else if (bus.store_go && pull_cnt_ff == '0) begin
            pull_cnt_ff <= PW'(nvsc_pkg::STORE_PULSE_CYC);
            sb_oe_ff    <= 1'b1;
        end else if (pull_cnt_ff != '0) begin
            pull_cnt_ff <= pull_cnt_ff - PW'(1);
            sb_oe_ff    <= (pull_cnt_ff != PW'(1));
        end else begin
            sb_oe_ff    <= 1'b0;
        end
    end

    // lockout restarts whenever the pin is seen low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_cnt_ff <= LW'(nvsc_pkg::LOCKOUT_CYC);
        end else if (!sync_ff) begin
            lock_cnt_ff <= LW'(nvsc_pkg::LOCKOUT_CYC); // [RL19]
        end else if (lock_cnt_ff != '0) begin
            lock_cnt_ff <= lock_cnt_ff - LW'(1);
        end
    end

    // startup hold covers the power-up recall even before the pin falls
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_cnt_ff <= SW'(STARTUP_CYC);
        end else if (start_cnt_ff != '0) begin
            start_cnt_ff <= start_cnt_ff - SW'(1); // [RL21]
        end
    end

    assign sb_o          = 1'b0; // open drain: only ever pulls low
    assign sb_oe         = sb_oe_ff;
    assign bus.pull_idle = !sb_oe_ff && pull_cnt_ff == '0;
    assign bus.busy      = !sync_ff;
    // pin held low by anyone blocks us until it is released
    assign bus.access_ok = bus.pull_idle && sync_ff && lock_cnt_ff == '0
                           && start_cnt_ff == '0; // [RL18]

    chk_low_blocks_access: assert property (@(posedge clk) disable iff (!rst_n) // [RL18]
        !sync_ff |-> !bus.access_ok)
        else $error("access allowed while store_busy_n low");

    chk_lockout_after_rise: assert property (@(posedge clk) disable iff (!rst_n) // [RL19]
        $rose(sync_ff) |-> !bus.access_ok)
        else $error("access allowed inside post-busy lockout");

    chk_pull_holds: assert property (@(posedge clk) disable iff (!rst_n) // [RL18]
        $rose(sb_oe_ff) |-> sb_oe_ff ##1 sb_oe_ff ##1 sb_oe_ff)
        else $error("store pull shorter than required");
endmodule : nvsc_busy_mon

// ### nvsc_ctrl.sv
// Purpose: host-side access engine for an asynchronous nonvolatile sram
// Assumes: pins are asynchronous; device handles store/recall internally
// Notes:   one access at a time; reads retried if busy falls mid-cycle
`timescale 1ns/100ps
module nvsc_ctrl #(
    parameter int DATA_W      = 16,
    parameter int ADDR_W      = 19,
    parameter int STARTUP_CYC = nvsc_pkg::RECALL_CYC
) (
    input  wire logic              MCLK,
    input  wire logic              RST_N,
    input  wire logic              REQ_VALID,
    output logic                   REQ_READY,
    input  wire logic              REQ_WRITE,
    input  wire logic [ADDR_W-1:0] REQ_ADDR,
    input  wire logic [DATA_W-1:0] REQ_WDATA,
    input  wire logic [1:0]        REQ_LANES,
    output logic                   RSP_VALID,
    output logic [DATA_W-1:0]      RSP_RDATA,
    input  wire logic              STORE_REQ,
    output logic                   STORE_PENDING,
    output logic                   DEV_BUSY,
    output logic [ADDR_W-1:0]      MEM_ADDR,
    output logic                   MEM_CE_N,
    output logic                   MEM_OE_N,
    output logic                   MEM_WE_N,
    output logic                   MEM_HIGH_LANE_ENABLE_N,
    output logic                   MEM_LOW_LANE_ENABLE_N,
    input  wire logic [DATA_W-1:0] MEM_DQ_I,
    output logic [DATA_W-1:0]      MEM_DQ_O,
    output logic                   MEM_DQ_OE,
    input  wire logic              MEM_STORE_BUSY_N_I,
    output logic                   MEM_STORE_BUSY_N_O,
    output logic                   MEM_STORE_BUSY_N_OE
);
    // byte-wide parts use 20 address bits, word-wide parts 19
    if (!((DATA_W == 16 && ADDR_W == 19) || (DATA_W == 8 && ADDR_W == 20))) begin : g_chk
        $error("DATA_W/ADDR_W must be 16/19 or 8/20"); // [RL3]
    end

    nvsc_busy_if bif ();

    nvsc_busy_mon #(
        .STARTUP_CYC (STARTUP_CYC)
    ) u_mon (
        .clk   (MCLK),
        .rst_n (RST_N),
        .sb_i  (MEM_STORE_BUSY_N_I),
        .sb_o  (MEM_STORE_BUSY_N_O),
        .sb_oe (MEM_STORE_BUSY_N_OE),
        .bus   (bif.mon)
    );

    nvsc_pkg::nvsc_state_t state_ff;
    nvsc_pkg::nvsc_state_t nxt_state;
    logic [7:0]            cnt_ff;
    logic                  pend_ff;
    logic                  wr_ff;
    logic [ADDR_W-1:0]     addr_ff;
    logic [DATA_W-1:0]     wdata_ff;
    logic [1:0]            lanes_ff;
    logic                  store_pend_ff;
    logic [DATA_W-1:0]     dq_meta_ff;
    logic [DATA_W-1:0]     dq_sync_ff;
    logic                  ce_n_ff;
    logic                  oe_n_ff;
    logic                  we_n_ff;
    logic                  dq_oe_ff;
    logic                  rsp_ff;
    logic [DATA_W-1:0]     rdata_ff;
    logic                  accept;
    logic                  phase_done;

    // a pending store keeps new accesses out so the pull meets an idle bus
    assign REQ_READY = state_ff == nvsc_pkg::S_IDLE && bif.access_ok && !store_pend_ff;
    assign accept    = REQ_VALID && REQ_READY;
    assign bif.store_go = store_pend_ff && state_ff == nvsc_pkg::S_IDLE && bif.pull_idle;

    // phase length by state
    always_comb begin
        case (state_ff)
            nvsc_pkg::S_RD:       phase_done = cnt_ff == 8'(nvsc_pkg::RD_CYC - 1);
            nvsc_pkg::S_WR_SETUP: phase_done = cnt_ff == 8'(nvsc_pkg::TURN_CYC - 1);
            nvsc_pkg::S_WR_PULSE: phase_done = cnt_ff == 8'(nvsc_pkg::WE_CYC - 1);
            default:              phase_done = 1'b1;
        endcase
    end

    // next state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            nvsc_pkg::S_WAIT: begin
                if (!pend_ff) begin
                    nxt_state = nvsc_pkg::S_IDLE;
                end else if (bif.access_ok) begin
                    nxt_state = wr_ff ? nvsc_pkg::S_WR_SETUP : nvsc_pkg::S_RD;
                end
            end
            nvsc_pkg::S_IDLE: begin
                if (accept) begin
                    nxt_state = REQ_WRITE ? nvsc_pkg::S_WR_SETUP : nvsc_pkg::S_RD;
                end
            end
            nvsc_pkg::S_RD: begin
                // data read while busy low is not valid: drop and retry
                if (!bif.access_ok) begin
                    nxt_state = nvsc_pkg::S_WAIT; // [RL2]
                end else if (phase_done) begin
                    nxt_state = nvsc_pkg::S_IDLE;
                end
            end
            nvsc_pkg::S_WR_SETUP: begin
                if (phase_done) begin
                    nxt_state = nvsc_pkg::S_WR_PULSE;
                end
            end
            nvsc_pkg::S_WR_PULSE: begin
                // a started write runs out; the device grants it time
                if (phase_done) begin
                    nxt_state = nvsc_pkg::S_WR_END;
                end
            end
            nvsc_pkg::S_WR_END: nxt_state = nvsc_pkg::S_IDLE;
            default:            nxt_state = nvsc_pkg::S_WAIT;
        endcase
    end

    // state and phase counter
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            state_ff <= nvsc_pkg::S_WAIT;
            cnt_ff   <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= (nxt_state != state_ff) ? 8'h00 : cnt_ff + nvsc_pkg::CNT_W8_ONE;
        end
    end

    // request latch; address stays put until the cycle is over
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            pend_ff  <= 1'b0;
            wr_ff    <= 1'b0;
            addr_ff  <= '0;
            wdata_ff <= '0;
            lanes_ff <= 2'h0;
        end else if (accept) begin
            pend_ff  <= 1'b1;
            wr_ff    <= REQ_WRITE;
            addr_ff  <= REQ_ADDR; // [RL7]
            wdata_ff <= REQ_WDATA;
            lanes_ff <= REQ_LANES;
        end else if (nxt_state == nvsc_pkg::S_IDLE) begin
            pend_ff  <= 1'b0;
        end
    end

    // store request held until the engine is idle; new request wins clear
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            store_pend_ff <= 1'b0;
        end else if (STORE_REQ) begin
            store_pend_ff <= 1'b1;
        end else if (bif.store_go) begin
            store_pend_ff <= 1'b0;
        end
    end

    // two-stage sampling of the data pins
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            dq_meta_ff <= '0;
            dq_sync_ff <= '0;
        end else begin
            dq_meta_ff <= MEM_DQ_I;
            dq_sync_ff <= dq_meta_ff;
        end
    end

    // pin controls registered from the next state so they never glitch
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            ce_n_ff  <= 1'b1;
            oe_n_ff  <= 1'b1;
            we_n_ff  <= 1'b1;
            dq_oe_ff <= 1'b0;
        end else begin
            ce_n_ff  <= !(nxt_state inside {nvsc_pkg::S_RD, nvsc_pkg::S_WR_SETUP,
                                            nvsc_pkg::S_WR_PULSE}); // [RL2] [RL6]
            oe_n_ff  <= nxt_state != nvsc_pkg::S_RD;                // [RL9]
            we_n_ff  <= nxt_state != nvsc_pkg::S_WR_PULSE;          // [RL6]
            // data stays driven one cycle past the rising edge for hold
            dq_oe_ff <= nxt_state inside {nvsc_pkg::S_WR_PULSE, nvsc_pkg::S_WR_END};
        end
    end

    // read data and completion pulse
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            rsp_ff   <= 1'b0;
            rdata_ff <= '0;
        end else begin
            rsp_ff <= (state_ff == nvsc_pkg::S_RD && bif.access_ok && phase_done)
                      || state_ff == nvsc_pkg::S_WR_END;
            // an aborted read keeps the last good data on the output
            if (state_ff == nvsc_pkg::S_RD && bif.access_ok && phase_done) begin
                rdata_ff <= dq_sync_ff;
            end
        end
    end

    assign RSP_VALID              = rsp_ff;
    assign RSP_RDATA              = rdata_ff;
    assign STORE_PENDING          = store_pend_ff;
    assign DEV_BUSY               = bif.busy;
    assign MEM_ADDR               = addr_ff;
    assign MEM_CE_N               = ce_n_ff;
    assign MEM_OE_N               = oe_n_ff;
    assign MEM_WE_N               = we_n_ff;
    assign MEM_HIGH_LANE_ENABLE_N = !lanes_ff[1];
    assign MEM_LOW_LANE_ENABLE_N  = !lanes_ff[0];
    assign MEM_DQ_O               = wdata_ff;
    assign MEM_DQ_OE              = dq_oe_ff;

    chk_read_we_high: assert property (@(posedge MCLK) disable iff (!RST_N) // [RL2]
        (!MEM_CE_N && !MEM_OE_N) |-> MEM_WE_N && !MEM_DQ_OE)
        else $error("read with write enable low or data driven");

    chk_write_oe_high: assert property (@(posedge MCLK) disable iff (!RST_N) // [RL9]
        !MEM_WE_N |-> MEM_OE_N && !MEM_CE_N && MEM_DQ_OE)
        else $error("write pulse without CE low, OE high, data driven");

    chk_write_start_ok: assert property (@(posedge MCLK) disable iff (!RST_N) // [RL6] [RL2]
        $rose(!MEM_CE_N) |-> $past(bif.access_ok))
        else $error("access started while busy or locked out");

    chk_addr_stable: assert property (@(posedge MCLK) disable iff (!RST_N) // [RL7]
        (!MEM_CE_N && $past(!MEM_CE_N)) |-> $stable(MEM_ADDR))
        else $error("address changed inside a cycle");

    chk_we_pulse_len: assert property (@(posedge MCLK) disable iff (!RST_N) // [RL7]
        $fell(MEM_WE_N) |-> !MEM_WE_N[*5] ##1 (MEM_WE_N && MEM_DQ_OE))
        else $error("write pulse length or data hold wrong");
endmodule : nvsc_ctrl

// ### nvsc_dev_model.sv
// Purpose: behavioural model of the nonvolatile sram seen from its pins
// Assumes: x16 organisation; times in ns; small array aliased on low address bits
// Notes:   released data lines show the inverse of the stored byte, never a copy
`timescale 1ns/100ps
module nvsc_dev_model #(
    parameter int T_AA     = 20,
    parameter int T_RECALL = 400,
    parameter int T_DELAY  = 40,
    parameter int T_STORE  = 200,
    parameter int BUSY_RELEASE_DRIVE_TIME   = 8,
    parameter int T_LZ     = 20
) (
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        hle_n,
    input  wire logic        lle_n,
    input  wire logic [18:0] addr,
    input  wire logic [15:0] dq_in,
    input  wire logic        sb,
    input  wire logic        supply_low,
    input  wire logic        soft_store,
    output wire logic [15:0] dq_out,
    output logic             dev_low,
    output logic             wflag,
    output logic [7:0]       store_cnt
);
    logic [15:0] mem [0:255];
    logic        rcl_done;
    logic        lock;
    logic        dev_high;
    logic        wr_ok;
    wire logic   blocked = !sb || lock || !rcl_done;
    wire logic   wr_act  = !ce_n && !we_n;
    wire logic   rd      = !ce_n && !oe_n && we_n && !blocked;
    wire logic [15:0] m  = mem[addr[7:0]];

    // enabled lanes only; a released lane shows a wrong value on purpose
    assign #(T_AA) dq_out = {(rd && !hle_n) ? m[15:8] : ~m[15:8],
                             (rd && !lle_n) ? m[7:0] : ~m[7:0]};

    // power-up recall holds the busy pin low; the write flag starts cleared before it
    initial begin
        dev_low = 1'b1;
        dev_high = 1'b0;
        rcl_done = 1'b0;
        lock = 1'b0;
        wr_ok = 1'b0;
        wflag = 1'b0;
        store_cnt = 8'h00;
        #(T_RECALL);
        dev_low = 1'b0;
        rcl_done = 1'b1;
    end

    // lockout after every return of the pin to high
    always @(posedge sb) begin
        lock = 1'b1;
        #(T_LZ);
        lock = 1'b0;
    end

    // a write begun while blocked is dropped; one in flight finishes
    always @(posedge wr_act) wr_ok = !blocked;
    always @(negedge wr_act) begin
        if (wr_ok) begin
            if (!lle_n) mem[addr[7:0]][7:0] = dq_in[7:0];
            if (!hle_n) mem[addr[7:0]][15:8] = dq_in[15:8];
            wflag = 1'b1;
        end
    end

    // one store: pin held low throughout; dev_high is set briefly after but never reaches the pin
    task automatic run_store;
        dev_low = 1'b1;
        #(T_STORE);
        wflag = 1'b0;
        store_cnt = store_cnt + 8'h01;
        dev_low = 1'b0;
        dev_high = 1'b1;
        #(BUSY_RELEASE_DRIVE_TIME);
        dev_high = 1'b0;
    endtask : run_store

    // pin store: skipped when nothing was written since the last transfer
    // our own busy pull is not a request, so it must not start another
    always @(negedge sb) begin
        if (rcl_done && !dev_low) begin
            #(T_DELAY);
            if (wflag) run_store();
        end
    end

    // supply drop: backup capacitor powers one store if anything was written
    always @(posedge supply_low) if (wflag) run_store();

    // software store runs whether or not anything was written
    always @(posedge soft_store) run_store();
endmodule : nvsc_dev_model

// ### testbench.sv
// Purpose: self-checking bench for the nonvolatile sram host controller
// Assumes: startup wait shortened to 20 cycles; device model answers in ns
// Notes:   inputs change on the falling edge; outputs judged there too
`timescale 1ns/100ps
module testbench;
    logic        MCLK;
    logic        RST_N;
    logic        req_valid;
    logic        req_write;
    logic [18:0] req_addr;
    logic [15:0] req_wdata;
    logic [1:0]  req_lanes;
    logic        store_req;
    logic        supply_low;
    logic        soft_store;
    int          errors;
    int          num_checks;
    int          hi_cnt;
    logic        wr_prev;
    logic [18:0] a_prev;
    wire logic        REQ_READY, RSP_VALID, STORE_PENDING, DEV_BUSY;
    wire logic [15:0] RSP_RDATA, dq_o, dev_dq;
    wire logic [18:0] MEM_ADDR;
    wire logic        MEM_CE_N, MEM_OE_N, MEM_WE_N, hle_n, lle_n, dq_oe;
    wire logic        sb_o, sb_oe, dev_low, wflag;
    wire logic [7:0]  store_cnt;
    // open-drain pin with pull-up; host data wins only while it drives
    wire logic        sb     = !((sb_oe && !sb_o) || dev_low);
    wire logic [15:0] dq_bus = dq_oe ? dq_o : dev_dq;

    nvsc_ctrl #(.STARTUP_CYC(20)) i_nvsc_ctrl (
        .MCLK(MCLK), .RST_N(RST_N), .REQ_VALID(req_valid), .REQ_READY(REQ_READY),
        .REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
        .REQ_LANES(req_lanes), .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA),
        .STORE_REQ(store_req), .STORE_PENDING(STORE_PENDING), .DEV_BUSY(DEV_BUSY),
        .MEM_ADDR(MEM_ADDR), .MEM_CE_N(MEM_CE_N), .MEM_OE_N(MEM_OE_N), .MEM_WE_N(MEM_WE_N),
        .MEM_HIGH_LANE_ENABLE_N(hle_n), .MEM_LOW_LANE_ENABLE_N(lle_n), .MEM_DQ_I(dq_bus),
        .MEM_DQ_O(dq_o), .MEM_DQ_OE(dq_oe), .MEM_STORE_BUSY_N_I(sb),
        .MEM_STORE_BUSY_N_O(sb_o), .MEM_STORE_BUSY_N_OE(sb_oe));

    nvsc_dev_model i_nvsc_dev_model (
        .ce_n(MEM_CE_N), .oe_n(MEM_OE_N), .we_n(MEM_WE_N), .hle_n(hle_n), .lle_n(lle_n),
        .addr(MEM_ADDR), .dq_in(dq_bus), .sb(sb), .dq_out(dev_dq), .dev_low(dev_low),
        .wflag(wflag), .store_cnt(store_cnt), .supply_low(supply_low), .soft_store(soft_store));

    initial MCLK = 1'b0;
    always #2 MCLK = ~MCLK;

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_sim

    // cycles the pin has stayed high, for judging the lockout at each take
    always @(posedge MCLK) hi_cnt <= (sb === 1'b1) ? hi_cnt + 1 : 0;

    // pin-level watch: output enable off and address steady while writing
    always @(negedge MCLK) begin
        if (MEM_WE_N === 1'b0) chk("oe_in_write", 16'h0001, {15'h0, MEM_OE_N});
        if (wr_prev) chk("addr_hold", {13'h0, a_prev[18:16]}, {13'h0, MEM_ADDR[18:16]});
        if (wr_prev) chk("addr_hold_lo", a_prev[15:0], MEM_ADDR[15:0]);
        wr_prev = (MEM_CE_N === 1'b0) && (MEM_WE_N === 1'b0);
        a_prev = MEM_ADDR;
    end

    task automatic xfer(input logic w, input logic [18:0] a, input logic [15:0] d,
                        input logic [1:0] l, output logic [15:0] q);
        int n;
        @(negedge MCLK);
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        req_lanes = l;
        n = 0;
        while (REQ_READY !== 1'b1 && n < 2000) begin
            @(negedge MCLK);
            n++;
        end
        if (n >= 2000) begin
            errors++;
            end_sim();
        end
        chk("pin_quiet", 16'h0001, {15'h0, hi_cnt >= nvsc_pkg::LOCKOUT_CYC});
        @(negedge MCLK);
        req_valid = 1'b0;
        n = 0;
        while (RSP_VALID !== 1'b1 && n < 300) begin
            @(negedge MCLK);
            n++;
        end
        if (n >= 300) begin
            errors++;
            end_sim();
        end
        q = RSP_RDATA;
    endtask : xfer

    task automatic wait_sb(input logic v);
        int n;
        n = 0;
        while (sb !== v && n < 1000) begin
            @(negedge MCLK);
            n++;
        end
        if (n >= 1000) begin
            errors++;
            end_sim();
        end
    endtask : wait_sb

    task automatic pulse_store;
        @(negedge MCLK);
        store_req = 1'b1;
        @(negedge MCLK);
        store_req = 1'b0;
    endtask : pulse_store

    // full words, single lanes and the top address
    task automatic t_lanes;
        logic [15:0] q;
        xfer(1'b1, 19'h00010, 16'h1234, 2'b11, q);
        xfer(1'b0, 19'h00010, 16'h0000, 2'b11, q);
        chk("rd_full", 16'h1234, q);
        xfer(1'b1, 19'h00010, 16'hABCD, 2'b01, q);
        xfer(1'b0, 19'h00010, 16'h0000, 2'b11, q);
        chk("wr_low_lane", 16'h12CD, q);
        xfer(1'b1, 19'h00010, 16'h5E00, 2'b10, q);
        xfer(1'b0, 19'h00010, 16'h0000, 2'b10, q);
        chk("rd_high_lane", 16'h5E00, q & 16'hFF00);
        xfer(1'b1, 19'h7FFFF, 16'hC33C, 2'b11, q);
        xfer(1'b0, 19'h7FFFF, 16'h0000, 2'b11, q);
        chk("rd_top_addr", 16'hC33C, q);
        $display("done t_lanes");
    endtask : t_lanes

    // pin store after a write, then a request with nothing written
    task automatic t_store;
        logic [15:0] q;
        logic [7:0]  c0;
        xfer(1'b1, 19'h00055, 16'h0F0F, 2'b11, q);
        c0 = store_cnt;
        pulse_store();
        chk("store_pend", 16'h0001, {15'h0, STORE_PENDING});
        wait_sb(1'b0);
        repeat (4) @(negedge MCLK);
        chk("busy_seen", 16'h0001, {15'h0, DEV_BUSY});
        chk("ready_in_busy", 16'h0000, {15'h0, REQ_READY});
        wait_sb(1'b1);
        chk("store_done", {8'h0, c0 + 8'h01}, {8'h0, store_cnt});
        chk("wflag_clear", 16'h0000, {15'h0, wflag});
        xfer(1'b0, 19'h00055, 16'h0000, 2'b11, q);
        chk("rd_after_store", 16'h0F0F, q);
        c0 = store_cnt;
        pulse_store();
        wait_sb(1'b0);
        wait_sb(1'b1);
        repeat (80) @(negedge MCLK);
        chk("store_skipped", {8'h0, c0}, {8'h0, store_cnt});
        xfer(1'b0, 19'h00055, 16'h0000, 2'b11, q);
        chk("rd_after_skip", 16'h0F0F, q);
        $display("done t_store");
    endtask : t_store

    // device-started stores: software kick mid-read, then supply drops
    task automatic t_devstore;
        logic [15:0] q;
        logic [7:0]  c0;
        xfer(1'b1, 19'h00066, 16'hA55A, 2'b11, q);
        c0 = store_cnt;
        fork
            xfer(1'b0, 19'h00066, 16'h0000, 2'b11, q);
            begin
                repeat (4) @(negedge MCLK);
                soft_store = 1'b1;
            end
        join
        soft_store = 1'b0;
        chk("rd_across_store", 16'hA55A, q);
        chk("soft_store_wr", {8'h0, c0 + 8'h01}, {8'h0, store_cnt});
        @(negedge MCLK);
        soft_store = 1'b1;
        wait_sb(1'b0);
        repeat (4) @(negedge MCLK);
        chk("ready_dev_busy", 16'h0000, {15'h0, REQ_READY});
        wait_sb(1'b1);
        soft_store = 1'b0;
        chk("soft_store_nowr", {8'h0, c0 + 8'h02}, {8'h0, store_cnt});
        supply_low = 1'b1;
        repeat (80) @(negedge MCLK);
        supply_low = 1'b0;
        chk("drop_no_write", {8'h0, c0 + 8'h02}, {8'h0, store_cnt});
        xfer(1'b1, 19'h00067, 16'h3C3C, 2'b11, q);
        supply_low = 1'b1;
        wait_sb(1'b0);
        wait_sb(1'b1);
        supply_low = 1'b0;
        chk("drop_store", {8'h0, c0 + 8'h03}, {8'h0, store_cnt});
        xfer(1'b0, 19'h00067, 16'h0000, 2'b11, q);
        chk("rd_after_drop", 16'h3C3C, q);
        $display("done t_devstore");
    endtask : t_devstore

    initial begin
        RST_N = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 19'h00000;
        req_wdata = 16'h0000;
        req_lanes = 2'b00;
        store_req = 1'b0;
        supply_low = 1'b0;
        soft_store = 1'b0;
        errors = 0;
        num_checks = 0;
        hi_cnt = 0;
        wr_prev = 1'b0;
        a_prev = 19'h00000;
        repeat (5) @(negedge MCLK);
        RST_N = 1'b1;
        t_lanes();
        t_store();
        t_devstore();
        end_sim();
    end
endmodule : testbench
